// ===== match_action_params.svh
// offsets, field positions, reset values and widths for the match action block
`ifndef MATCH_ACTION_PARAMS_SVH
`define MATCH_ACTION_PARAMS_SVH

`define OUT_COUNT        23
`define LOW_OUT_COUNT    16
`define ACT_VEC_W        46
`define ADDR_W           12

`define ADDR_STATE       12'h088
`define ADDR_LOW         12'h08c
`define ADDR_HIGH        12'h090
`define ADDR_PWM         12'h094

`define HIGH_OUT22_LSB   12
`define HIGH_OUT22_MSB   13
`define OUT22_INDEX      22

`define STATE_RESET      23'h000000
`define PWM_RESET        23'h000000
`define LOW_RESET        32'h00000000
`define HIGH_FIELD_RESET 2'h0
`define RDATA_ZERO       32'h00000000

`endif

// ===== match_action_pkg.sv
// types and the action decode shared by the match action block
package match_action_pkg;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_LOW    = 2'h1,
        ACT_HIGH   = 2'h2,
        ACT_TOGGLE = 2'h3
    } action_t;

    // new pin level for one output when its match fires
    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        logic res;
        res = cur;
        case (action_t'(act))
            ACT_NONE:   res = cur;
            ACT_LOW:    res = 1'b0;
            ACT_HIGH:   res = 1'b1;
            ACT_TOGGLE: res = ~cur;
            default:    res = cur;
        endcase
        return res;
    endfunction

endpackage

// ===== match_apb_decode.sv
// apb address decode, write strobes and error answer
`include "match_action_params.svh"
module match_apb_decode
    import match_action_pkg::*;
(
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [`ADDR_W-1:0]  paddr,
    output logic                     pready,
    output logic                     pslverr,
    output logic [3:0]               sel_vec,
    output logic                     wr_state,
    output logic                     wr_low,
    output logic                     wr_high,
    output logic                     wr_pwm
);
    logic access;

    always_comb begin
        sel_vec = 4'h0;
        case (paddr)
            `ADDR_STATE: sel_vec = 4'h1;
            `ADDR_LOW:   sel_vec = 4'h2;
            `ADDR_HIGH:  sel_vec = 4'h4;
            `ADDR_PWM:   sel_vec = 4'h8;
            default:     sel_vec = 4'h0;
        endcase
    end

    // zero wait states: every access ends in its first access cycle
    assign access   = psel & penable;
    assign pready   = 1'b1;
    assign pslverr  = access & ~(|sel_vec);
    assign wr_state = access & pwrite & sel_vec[0];
    assign wr_low   = access & pwrite & sel_vec[1];
    assign wr_high  = access & pwrite & sel_vec[2];
    assign wr_pwm   = access & pwrite & sel_vec[3];
endmodule

// ===== match_action_apply.sv
// per-output action applied on a match event
`include "match_action_params.svh"
module match_action_apply
    import match_action_pkg::*;
(
    input  wire logic [`ACT_VEC_W-1:0] act_vec,
    input  wire logic [`OUT_COUNT-1:0] hit,
    input  wire logic [`OUT_COUNT-1:0] state_cur,
    output logic      [`OUT_COUNT-1:0] state_hw
);
    always_comb begin
        state_hw = state_cur;
        for (int k = 0; k < `OUT_COUNT; k++) begin
            if (hit[k]) begin
                state_hw[k] = apply_action(act_vec[2*k +: 2], state_cur[k]); // R1 R2
            end
        end
    end
endmodule

// ===== match_action_control.sv
// match output action control: registers, action apply, pwm override
// How it works
// [R1] A 2-bit action code of 00 keeps the pin, 01 drives it low and 10 drives it high on a match.
// [R2] Code 11 inverts the pin's present level on every match event.
// [R3] For outputs 0 to 15, output k's action field lies at bits 2k+1:2k of the low action register.
// [R4] A second action register at offset 0x90 carries control for output 22, the only upper output with an action field.
// [R5] Output 22's action field sits at bits 13:12 of that second register with the same codes.
// [R6] An output in pwm mode ignores its action field and follows the pwm level.
// [R7] All action fields are read/write and reset to zero so no pin moves on a match after reset.
// [R8] Each output has a state bit, and software writing 1 or 0 there drives the pin high or low unless the output is in pwm mode.
// [R9] The action is applied in the cycle the counter equals the match value, updating the state bit.
//
// Design decision made here: the APB register port.
`include "match_action_params.svh"
module match_action_control
    import match_action_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`ADDR_W-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [`OUT_COUNT-1:0] match_event,
    input  wire logic [`OUT_COUNT-1:0] pwm_level,
    output logic      [`OUT_COUNT-1:0] timer_match_output
);
    logic [`OUT_COUNT-1:0]  state_reg;
    logic [`OUT_COUNT-1:0]  state_next;
    logic [31:0]            low_reg;
    logic [31:0]            low_next;
    logic [1:0]             out22_reg;
    logic [1:0]             out22_next;
    logic [`OUT_COUNT-1:0]  pwm_reg;
    logic [`OUT_COUNT-1:0]  pwm_next;
    logic [31:0]            prdata_reg;
    logic [31:0]            prdata_next;
    logic [`ACT_VEC_W-1:0]  act_vec;
    logic [`OUT_COUNT-1:0]  hit;
    logic [`OUT_COUNT-1:0]  state_hw;
    logic [3:0]             sel_vec;
    logic                   wr_state;
    logic                   wr_low;
    logic                   wr_high;
    logic                   wr_pwm;
    logic                   setup;

    match_apb_decode u_decode (
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pready   (pready),
        .pslverr  (pslverr),
        .sel_vec  (sel_vec),
        .wr_state (wr_state),
        .wr_low   (wr_low),
        .wr_high  (wr_high),
        .wr_pwm   (wr_pwm)
    );

    // action vector, two bits per output
    always_comb begin
        act_vec = '0;
        for (int k = 0; k < `LOW_OUT_COUNT; k++) begin
            act_vec[2*k +: 2] = low_reg[2*k +: 2]; // R3
        end
        // outputs 16 to 21 have no action source here and stay at do nothing
        act_vec[2*`OUT22_INDEX +: 2] = out22_reg; // R5
    end

    // pwm outputs never see a match action
    assign hit = match_event & ~pwm_reg; // R6 R9

    match_action_apply u_apply (
        .act_vec   (act_vec),
        .hit       (hit),
        .state_cur (state_reg),
        .state_hw  (state_hw)
    );

    // state bits: software write first, hardware match wins on the same bit
    always_comb begin
        state_next = state_reg;
        if (wr_state) begin
            state_next = pwdata[`OUT_COUNT-1:0]; // R8
        end
        for (int k = 0; k < `OUT_COUNT; k++) begin
            if (hit[k]) begin
                state_next[k] = state_hw[k]; // R9
            end
        end
    end

    // action and mode registers
    always_comb begin
        low_next   = low_reg;
        out22_next = out22_reg;
        pwm_next   = pwm_reg;
        if (wr_low) begin
            low_next = pwdata; // R7
        end
        if (wr_high) begin
            out22_next = pwdata[`HIGH_OUT22_MSB:`HIGH_OUT22_LSB]; // R4 R5
        end
        if (wr_pwm) begin
            pwm_next = pwdata[`OUT_COUNT-1:0];
        end
    end

    // read data captured in the setup cycle so prdata comes from a flop
    assign setup = psel & ~penable;

    always_comb begin
        prdata_next = prdata_reg;
        if (setup) begin
            case (sel_vec)
                4'h1:    prdata_next = {9'h000, state_reg};
                4'h2:    prdata_next = low_reg;
                4'h4:    prdata_next = {18'h00000, out22_reg, 12'h000}; // R4
                4'h8:    prdata_next = {9'h000, pwm_reg};
                default: prdata_next = `RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= `STATE_RESET;
            low_reg    <= `LOW_RESET; // R7
            out22_reg  <= `HIGH_FIELD_RESET; // R7
            pwm_reg    <= `PWM_RESET;
            prdata_reg <= `RDATA_ZERO;
        end else begin
            state_reg  <= state_next;
            low_reg    <= low_next;
            out22_reg  <= out22_next;
            pwm_reg    <= pwm_next;
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // pin follows pwm level in pwm mode, the state bit otherwise
    always_comb begin
        for (int k = 0; k < `OUT_COUNT; k++) begin
            timer_match_output[k] = pwm_reg[k] ? pwm_level[k] : state_reg[k]; // R6 R8
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_write_low;
        psel && penable && pwrite && paddr == `ADDR_LOW;
    endsequence

    sequence s_write_high;
        psel && penable && pwrite && paddr == `ADDR_HIGH;
    endsequence

    sequence s_read_high;
        psel && !penable && !pwrite && paddr == `ADDR_HIGH;
    endsequence

    sequence s_read_low;
        psel && !penable && !pwrite && paddr == `ADDR_LOW;
    endsequence

    sequence s_read_state;
        psel && !penable && !pwrite && paddr == `ADDR_STATE;
    endsequence

    sequence s_quiet0;
        !pwm_reg[0] && !wr_state;
    endsequence

    AST_NONE_KEEPS: assert property ( // R1
        s_quiet0 and (match_event[0] && low_reg[1:0] == 2'h0)
        |=> state_reg[0] == $past(state_reg[0]))
        else $error("do nothing action changed output 0");

    AST_LOW_DRIVES: assert property ( // R1
        (match_event[0] && !pwm_reg[0] && low_reg[1:0] == 2'h1)
        |=> !state_reg[0] && (pwm_reg[0] || !timer_match_output[0]))
        else $error("low action did not drive output 0 low");

    AST_HIGH_DRIVES: assert property ( // R1
        (match_event[3] && !pwm_reg[3] && low_reg[7:6] == 2'h2)
        |=> state_reg[3])
        else $error("high action did not drive output 3 high");

    AST_TOGGLE_INVERTS: assert property ( // R2
        s_quiet0 and (match_event[0] && low_reg[1:0] == 2'h3)
        |=> state_reg[0] != $past(state_reg[0]))
        else $error("toggle action did not invert output 0");

    AST_FIELD_PLACE: assert property ( // R3
        s_write_low ##1 (match_event[9] && !pwm_reg[9] && !wr_state)
        |=> state_reg[9] == apply_action($past(pwdata[19:18], 2), $past(state_reg[9])))
        else $error("output 9 field not taken from bits 19:18");

    AST_HIGH_READBACK: assert property ( // R4
        s_read_high ##1 (psel && penable)
        |-> prdata[31:14] == 18'h00000 && prdata[11:0] == 12'h000 && !pslverr)
        else $error("high action register read wrong");

    AST_OUT22_FIELD: assert property ( // R5
        s_write_high ##1 (match_event[22] && !pwm_reg[22] && !wr_state && !wr_high)
        |=> state_reg[22] == apply_action($past(pwdata[13:12], 2), $past(state_reg[22])))
        else $error("output 22 action not taken from bits 13:12");

    AST_PWM_OVERRIDE: assert property ( // R6
        pwm_reg[5] && match_event[5] && !wr_state
        |-> timer_match_output[5] == pwm_level[5] ##1 state_reg[5] == $past(state_reg[5]))
        else $error("pwm output was moved by its match action");

    AST_ACTION_RESET: assert property ( // R7
        $rose(presetn) |-> low_reg == `LOW_RESET && out22_reg == `HIGH_FIELD_RESET)
        else $error("action fields not zero after reset");

    AST_SW_STATE: assert property ( // R8
        wr_state && !(|match_event)
        |=> state_reg == $past(pwdata[`OUT_COUNT-1:0])
            && (timer_match_output & ~pwm_reg) == (state_reg & ~pwm_reg))
        else $error("state write did not reach the outputs");

    // second cycle judged on what happened in the first, not on new events
    AST_MATCH_SAME_CYCLE: assert property ( // R9
        wr_state && match_event[1] && !pwm_reg[1] && low_reg[3:2] == 2'h2
        |=> state_reg[1] ##1 (state_reg[1] || $past(match_event[1]) || $past(wr_state)))
        else $error("match action lost against state write");

    AST_UPPER_IDLE: assert property ( // R1
        (|(match_event[21:16] & ~pwm_reg[21:16])) && !wr_state
        |=> state_reg[21:16] == $past(state_reg[21:16]))
        else $error("outputs 16 to 21 moved on a match");

    AST_LOW22_DRIVES: assert property ( // R1 R5
        match_event[22] && !pwm_reg[22] && out22_reg == 2'h1
        |=> !state_reg[22])
        else $error("low action did not drive output 22 low");

    AST_HIGH22_DRIVES: assert property ( // R5
        match_event[22] && !pwm_reg[22] && out22_reg == 2'h2
        |=> state_reg[22])
        else $error("high action did not drive output 22 high");

    AST_TOGGLE22_INVERTS: assert property ( // R2
        match_event[22] && !pwm_reg[22] && !wr_state && out22_reg == 2'h3
        |=> state_reg[22] != $past(state_reg[22]))
        else $error("toggle action did not invert output 22");

    AST_FIELD5_HIGH: assert property ( // R3
        match_event[5] && !pwm_reg[5] && low_reg[11:10] == 2'h2
        |=> state_reg[5])
        else $error("output 5 field not taken from bits 11:10");

    AST_FIELD9_LOW: assert property ( // R3
        match_event[9] && !pwm_reg[9] && low_reg[19:18] == 2'h1
        |=> !state_reg[9])
        else $error("output 9 low code not taken from bits 19:18");

    AST_HIGH_WRITE: assert property ( // R4 R5
        s_write_high
        |=> out22_reg == $past(pwdata[13:12]))
        else $error("high action register write lost");

    AST_HIGH_NO_ERR: assert property ( // R4
        s_write_high
        |-> pready && !pslverr)
        else $error("high action register write refused");

    AST_PWM_PIN: assert property ( // R6
        pwm_reg[0]
        |-> timer_match_output[0] == pwm_level[0])
        else $error("pwm output 0 does not follow pwm level");

    AST_PWM_STATE_KEEP: assert property ( // R6
        !wr_state
        |=> (state_reg & $past(pwm_reg)) == ($past(state_reg) & $past(pwm_reg)))
        else $error("state bit of a pwm output moved");

    AST_LOW_WRITE: assert property ( // R7
        s_write_low
        |=> low_reg == $past(pwdata))
        else $error("low action register write lost");

    AST_LOW_READBACK: assert property ( // R7
        s_read_low ##1 (psel && penable)
        |-> prdata == low_reg && !pslverr)
        else $error("low action register read wrong");

    AST_STATE_READBACK: assert property ( // R8
        s_read_state ##1 (psel && penable)
        |-> prdata == {9'h000, $past(state_reg)})
        else $error("state register read wrong");

    AST_QUIET_HOLDS: assert property ( // R9
        !(|match_event) && !wr_state
        |=> state_reg == $past(state_reg))
        else $error("state moved without match or write");

endmodule

// ===== match_pins_model.sv
// far-side model: pwm level source and pin activity counter
module match_pins_model
    import match_action_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [22:0] pins,
    output logic      [22:0] pwm_level,
    output logic      [31:0] pin_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [22:0] pins_last;

    // level moves every cycle so a stale pwm mux cannot hide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_level <= 23'h000000;
            pins_last <= 23'h000000;
            pin_edges <= 32'h00000000;
        end else begin
            pwm_level <= pwm_level + 23'h000001;
            pins_last <= pins;
            if (pins !== pins_last) begin
                pin_edges <= pin_edges + 32'h00000001;
            end
        end
    end
endmodule

// ===== match_action_control_bench.sv
// self-checking bench for the match output action control block
`include "match_action_params.svh"
module match_action_control_bench
    import match_action_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, lo, pin_edges;
    logic [22:0] match_event, pwm_level, pins, st, pw;
    logic [1:0]  hi;
    int          mismatches, checks_done;

    match_action_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .match_event(match_event), .pwm_level(pwm_level),
        .timer_match_output(pins));
    match_pins_model far (.pclk(pclk), .presetn(presetn), .pins(pins), .pwm_level(pwm_level),
        .pin_edges(pin_edges));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            mismatches++;
        end
    endtask

    // one apb transfer; waits on pready with a bound
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [22:0] nxt(input logic [22:0] s, input logic [22:0] ev);
        logic [1:0]  c;
        logic [22:0] q;
        q = s;
        for (int k = 0; k < 23; k++) begin
            c = (k < 16) ? lo[2*k +: 2] : ((k == 22) ? hi : 2'h0);
            if (ev[k] && !pw[k])
                q[k] = (c == 2'h1) ? 1'b0 : (c == 2'h2) ? 1'b1 : (c == 2'h3) ? ~s[k] : s[k];
        end
        return q;
    endfunction

    // events held n cycles; pins checked after every sampling edge
    task automatic pulse(input logic [22:0] v, input int n);
        @(posedge pclk);
        match_event <= v;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            if (i == n - 1) match_event <= 23'h000000;
            #1;
            st = nxt(st, v);
            chk({9'h000, pins & ~pw}, {9'h000, st & ~pw});
        end
    endtask

    // event raised at the edge that ends a write, so it is taken one edge later
    task automatic hit_now(input logic [22:0] v);
        match_event <= v;
        @(posedge pclk);
        match_event <= 23'h000000;
        #1;
        st = nxt(st, v);
        chk({9'h000, pins & ~pw}, {9'h000, st & ~pw});
    endtask

    task automatic setup(input logic [31:0] l, input logic [1:0] h, input logic [22:0] s);
        lo = l;
        hi = h;
        st = s;
        xfer(1'b1, `ADDR_LOW, l);
        xfer(1'b1, `ADDR_HIGH, {18'h00000, h, 12'h000});
        xfer(1'b1, `ADDR_STATE, {9'h000, s});
        #1 chk({9'h000, pins}, {9'h000, s});
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        match_event = 23'h000000;
        {lo, hi, st, pw} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, `ADDR_STATE, 32'h0); chk(r, 32'h0);
        xfer(1'b0, `ADDR_LOW, 32'h0); chk(r, 32'h0);
        xfer(1'b0, `ADDR_HIGH, 32'h0); chk(r, 32'h0);
        pulse(23'h7fffff, 2);
        chk(pin_edges, 32'h0);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            setup({16{c[1:0]}}, c[1:0], 23'h2a5a5a);
            pulse(23'h7fffff, 1);
            xfer(1'b0, `ADDR_STATE, 32'h0); chk(r, {9'h000, st});
        end
        $display("test codes done");
        setup(32'h00040800, 2'h0, 23'h000200);
        pulse(23'h7fffff, 1);
        xfer(1'b1, `ADDR_LOW, 32'h000c0000);
        lo = 32'h000c0000;
        hit_now(23'h000200);
        xfer(1'b1, `ADDR_HIGH, 32'h00002000);
        hi = 2'h2;
        hit_now(23'h400000);
        $display("test field place done");
        xfer(1'b1, `ADDR_HIGH, 32'hffffffff);
        xfer(1'b0, `ADDR_HIGH, 32'h0); chk(r, 32'h00003000);
        xfer(1'b1, `ADDR_LOW, 32'ha5a55a5a);
        xfer(1'b0, `ADDR_LOW, 32'h0); chk(r, 32'ha5a55a5a);
        $display("test readback done");
        setup(32'h00000003, 2'h3, 23'h000000);
        pulse(23'h400001, 3);
        $display("test toggle done");
        setup(32'h00000008, 2'h0, 23'h000000);
        match_event <= 23'h000002;
        xfer(1'b1, `ADDR_STATE, 32'h00000155);
        match_event <= 23'h000000;
        st = nxt(23'h000155, 23'h000002);
        #1 chk({9'h000, pins}, {9'h000, st});
        xfer(1'b0, `ADDR_STATE, 32'h0);
        chk(r, {9'h000, st});
        $display("test same cycle done");
        pw = 23'h000021;
        xfer(1'b1, `ADDR_PWM, 32'h21);
        pulse(23'h000021, 1);
        xfer(1'b0, `ADDR_STATE, 32'h0); chk(r, {9'h000, st});
        repeat (3) begin
            @(posedge pclk);
            #1 chk({30'h0, pins[5], pins[0]}, {30'h0, pwm_level[5], pwm_level[0]});
        end
        $display("test pwm done");
        xfer(1'b1, 12'h000, 32'hffffffff);
        chk({31'h0, e}, 32'h1);
        xfer(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test unmapped done");
        summarize();
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        summarize();
    end
endmodule
